// >>> bench/ipw_core_model.sv
// behavioural core: accepts a granted vector promptly or after four cycles
// assumes the grant is registered on the same clock
`timescale 1ns/1ps
`default_nettype none
module ipw_core_model
    import ipw_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire ipw_grant_t grant_i,
    input  wire logic       slow_i,
    output logic            ack_o
);
    logic [1:0] wait_reg;
    // ack only while the grant stands, one cycle each
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            wait_reg <= 2'h0;
        end else if (ack_o || !grant_i.valid) begin
            ack_o <= 1'b0;
            wait_reg <= 2'h0;
        end else begin
            wait_reg <= wait_reg + 2'h1;
            ack_o <= !slow_i || wait_reg == 2'h3;
        end
    end
endmodule // ipw_core_model
`default_nettype wire

// >>> bench/ipw_irq_ctrl_properties.sv
// checker of grant order and clock control at the controller ports
// bound into ipw_irq_ctrl from the bench top file
`timescale 1ns/1ps
`default_nettype none
module ipw_irq_props
    import ipw_pkg::*;
(
    input wire logic          CLOCK_I,
    input wire logic          RST_I,
    input wire logic          VEC_ACK_I,
    input wire logic          RETI_I,
    input wire logic          IRQ_O,
    input wire ipw_grant_t    GRANT_O,
    input wire ipw_clk_ctrl_t CLK_CTRL_O
);
    logic [3:1] svc_reg;
    logic [1:0] cur_lvl;
    assign cur_lvl = svc_reg[3] ? 2'h3 : svc_reg[2] ? 2'h2 : {1'b0, svc_reg[1]};
    // levels in service as seen from accepts and returns
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            svc_reg <= 3'h0;
        end else begin
            if (RETI_I && cur_lvl != 2'h0)
                svc_reg[cur_lvl] <= 1'b0;
            if (VEC_ACK_I && GRANT_O.valid && GRANT_O.level != 2'h0)
                svc_reg[GRANT_O.level] <= 1'b1;
        end
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    sequence s_accept;
        GRANT_O.valid && VEC_ACK_I;
    endsequence
    sequence s_halted;
        !CLK_CTRL_O.core_run && CLK_CTRL_O.periph_run;
    endsequence
    sequence s_xstop;
        !CLK_CTRL_O.periph_run && CLK_CTRL_O.base_timer_run;
    endsequence
    AST_NEST_HIGHER: assert property (GRANT_O.valid |-> GRANT_O.level > cur_lvl)
        else $error("grant at or below the level in service");
    AST_ONE_PER_ACCEPT: assert property (s_accept |=> !GRANT_O.valid)
        else $error("grant still valid after accept");
    AST_VEC_ADDR: assert property (GRANT_O.valid |-> GRANT_O.addr[2:0] == 3'h3 && GRANT_O.addr <= 8'h4B)
        else $error("grant address off the vector table");
    AST_LEVEL_SET: assert property (GRANT_O.valid |-> GRANT_O.level != 2'h0 &&
        (GRANT_O.level != 2'h3 || GRANT_O.addr < 8'h13))
        else $error("grant level not allowed for this vector");
    AST_HALT_OSC: assert property (s_halted |-> CLK_CTRL_O.base_timer_run &&
        $stable({CLK_CTRL_O.rc_en, CLK_CTRL_O.cf_en, CLK_CTRL_O.xtal_en, CLK_CTRL_O.pll_en}))
        else $error("oscillators changed in halt");
    AST_HALT_WAKE: assert property (s_halted ##1 IRQ_O |-> CLK_CTRL_O.core_run)
        else $error("halt not left on interrupt");
    AST_STOP_ALL_OFF: assert property (!CLK_CTRL_O.periph_run && !CLK_CTRL_O.base_timer_run
        |-> CLK_CTRL_O == 7'h00)
        else $error("clock left running in stop");
    AST_XSTOP_KEEP: assert property (s_xstop |-> !CLK_CTRL_O.core_run && !CLK_CTRL_O.rc_en &&
        !CLK_CTRL_O.cf_en && !CLK_CTRL_O.pll_en && $stable(CLK_CTRL_O.xtal_en))
        else $error("crystal stop clocks wrong");
endmodule // ipw_irq_props
`default_nettype wire

// >>> bench/tb_irq_priority_and_wake_ctrl.sv
// self-checking bench: bus, vector grants, nesting and standby wake
// assumes ipw_core_model and the checker file are compiled before it
`include "ipw_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_irq_priority_and_wake_ctrl
    import ipw_pkg::*;
;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic          psel = 1'b0;
    logic          pen = 1'b0;
    logic          pwr = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic [7:0]    ext = 8'h00;
    logic [38:0]   evt = 39'h0;
    logic          reti = 1'b0;
    logic          slow = 1'b0;
    logic          ack;
    logic          irq;
    ipw_grant_t    grant;
    ipw_clk_ctrl_t clk_ctrl;
    logic [15:0]   lfsr = 16'hEF49;
    int            n_fail = 0;
    int            tests_run = 0;
    int            cyc = 0;
    ipw_irq_ctrl u_dut (.CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .EXT_IRQ_I(ext), .PERIPH_EVT_I(evt), .VEC_ACK_I(ack), .RETI_I(reti), .GRANT_O(grant),
        .IRQ_O(irq), .CLK_CTRL_O(clk_ctrl));
    ipw_core_model u_core (.clk_i(clk), .rst_i(rst), .grant_i(grant), .slow_i(slow), .ack_o(ack));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop;
        end
    end
    task automatic report_and_stop;
        $display("mismatches %0d of %0d checks", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {1'b0, v[15:1]} ^ (v[0] ? 16'hB400 : 16'h0000);
    endfunction
    function automatic bit is_pin(input int s);
        return s inside {0, 1, 2, 4, 7, 8, 11, 17};
    endfunction
    function automatic logic [7:0] vec_addr(input int s);
        int v;
        v = (s > 0) + (s > 1) + (s > 6) + (s > 9) + (s > 14) + (s > 20) + (s > 22) + (s > 25) + (s > 32);
        return 8'h03 + 8'(v * 8);
    endfunction
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk("read data", r, exp);
        chk("slave error", e, experr);
    endtask
    task automatic fire(input logic [38:0] m);
        @(posedge clk);
        evt <= m;
        @(posedge clk);
        evt <= 39'h0;
    endtask
    task automatic ret;
        @(posedge clk);
        reti <= 1'b1;
        @(posedge clk);
        reti <= 1'b0;
    endtask
    task automatic clear_all;
        wr(`IPW_PEND_LO_OFS, 32'hFFFFFFFF);
        wr(`IPW_PEND_HI_OFS, 32'h0000007F);
    endtask
    // waits for a grant, compares it, then lets the core model take it
    task automatic wait_grant(input logic [7:0] a, input logic [1:0] l);
        int n;
        n = 0;
        while (grant.valid !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        chk("grant address", {24'h0, grant.addr}, {24'h0, a});
        chk("grant level", {30'h0, grant.level}, {30'h0, l});
        while (grant.valid === 1'b1 && n < 80) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic rnd_src(output int s);
        do begin
            lfsr = lfsr_next(lfsr);
            s = lfsr % 39;
        end while (is_pin(s));
    endtask
    task automatic wait_run;
        int n;
        n = 0;
        while (clk_ctrl.core_run !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
    endtask
    initial begin
        int s;
        int b;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdchk(`IPW_LEVEL_OFS, 32'h0, 1'b0);
        rdchk(8'h40, 32'h0, 1'b1);
        wr(`IPW_EXTCFG_OFS, 32'h0000FF00);
        wr(`IPW_EN_LO_OFS, 32'hFFFFFFFF);
        wr(`IPW_EN_HI_OFS, 32'h0000007F);
        for (s = 0; s < 39; s++) begin
            if (!is_pin(s)) begin
                lfsr = lfsr_next(lfsr);
                slow <= lfsr[0];
                fire(39'h1 << s);
                wait_grant(vec_addr(s), `IPW_LVL_L);
                clear_all;
                ret;
                chk("irq cleared", irq, 1'b0);
            end
        end
        for (int k = 0; k < 8; k++) begin
            rnd_src(s);
            rnd_src(b);
            fire((39'h1 << s) | (39'h1 << b));
            wait_grant(vec_addr(s) < vec_addr(b) ? vec_addr(s) : vec_addr(b), `IPW_LVL_L);
            clear_all;
            ret;
        end
        wr(`IPW_LEVEL_OFS, 32'h000000A4);
        fire(39'h0000008408);
        wait_grant(8'h13, `IPW_LVL_H);
        repeat (4) @(posedge clk);
        chk("refused grant", grant.valid, 1'b0);
        chk("irq line", irq, 1'b1);
        wr(`IPW_PEND_LO_OFS, 32'h00000008);
        ret;
        wait_grant(8'h2B, `IPW_LVL_H);
        wr(`IPW_PEND_LO_OFS, 32'h00008000);
        ret;
        wait_grant(8'h23, `IPW_LVL_L);
        fire(39'h1 << 23);
        wait_grant(8'h3B, `IPW_LVL_H);
        wr(`IPW_PEND_LO_OFS, 32'h00800400);
        ret;
        ret;
        wr(`IPW_LEVEL_OFS, 32'h00000001);
        ext <= 8'h01;
        repeat (4) @(posedge clk);
        ext <= 8'h00;
        wait_grant(8'h03, `IPW_LVL_X);
        clear_all;
        ret;
        wr(`IPW_LEVEL_OFS, 32'h0);
        wr(`IPW_STBY_OFS, 32'h1);
        repeat (2) @(posedge clk);
        chk("halt clocks", {25'h0, clk_ctrl}, 32'h38);
        fire(39'h1 << 24);
        wait_run;
        chk("halt wake", clk_ctrl.core_run, 1'b1);
        clear_all;
        ret;
        wr(`IPW_STBY_OFS, 32'h2);
        repeat (2) @(posedge clk);
        chk("stop clocks", {25'h0, clk_ctrl}, 32'h0);
        ext <= 8'h01;
        repeat (4) @(posedge clk);
        ext <= 8'h00;
        repeat (8) @(posedge clk);
        chk("edge pin kept stop", {25'h0, clk_ctrl}, 32'h0);
        fire(39'h1 << 5);
        wait_run;
        chk("stop wake", clk_ctrl.core_run, 1'b1);
        clear_all;
        ret;
        wr(`IPW_EXTCFG_OFS, 32'h0000FF01);
        wr(`IPW_STBY_OFS, 32'h2);
        ext <= 8'h01;
        repeat (2) @(posedge clk);
        chk("level pin stop", clk_ctrl.core_run, 1'b0);
        wait_run;
        chk("level pin wake", clk_ctrl.core_run, 1'b1);
        ext <= 8'h00;
        clear_all;
        ret;
        wr(`IPW_OSC_OFS, 32'h5);
        wr(`IPW_STBY_OFS, 32'h3);
        repeat (2) @(posedge clk);
        chk("crystal stop clocks", {25'h0, clk_ctrl}, 32'h12);
        fire(39'h1 << 9);
        wait_run;
        chk("base timer wake", {25'h0, clk_ctrl}, 32'h7A);
        report_and_stop;
    end
endmodule // tb_irq_priority_and_wake_ctrl
bind ipw_irq_ctrl ipw_irq_props u_props (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .VEC_ACK_I(VEC_ACK_I),
    .RETI_I(RETI_I), .IRQ_O(IRQ_O), .GRANT_O(GRANT_O), .CLK_CTRL_O(CLK_CTRL_O));
`default_nettype wire

// >>> design/ipw_irq_ctrl.sv
// interrupt arbiter with three levels and standby wake control
// assumes core and peripherals on CLOCK_I; external pins asynchronous
//
// What this block does
// - merge 39 sources onto 10 shared vector addresses
// - each vector is low or raised (highest for 03h and 0Bh, high for the rest), highest over high over low
// - refuse requests at or below the level in service; only higher nests
// - simultaneous requests: the highest level wins
// - same level: the smallest vector address wins
// - vector 13h gathers ext 2 and 4, timer 0 low, both usb bus-active
// - vector 23h gathers timer 0 high, ext 6, port-a usb device events
// - vector 2Bh gathers timer 1 bytes, ext 7, port-b usb device events
// - vector 3Bh gathers second serial unit and uart empty and done
// - halt stops the core only; oscillators keep running
// - halt ends on reset, watchdog reset or any interrupt
// - stop halts core, peripherals, pll and all oscillators
// - stop ends on reset, ext 0,1,2,4,5, port 0 or usb bus-active
// - ext 0 and 1 wake from stop only when set level-sensitive
// - crystal stop keeps base timer and the crystal state at entry
// - crystal stop also ends on a base timer request
//
// Design decisions made here: the address map and register access over APB.
`include "ipw_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ipw_irq_ctrl
    import ipw_pkg::*;
(
    input  wire logic                    CLOCK_I,
    input  wire logic                    RST_I,
    input  wire logic                    PSEL_I,
    input  wire logic                    PENABLE_I,
    input  wire logic                    PWRITE_I,
    input  wire logic [`IPW_ADDR_W-1:0]  PADDR_I,
    input  wire logic [31:0]             PWDATA_I,
    output logic      [31:0]             PRDATA_O,
    output logic                         PREADY_O,
    output logic                         PSLVERR_O,
    input  wire logic [`IPW_NUM_EXT-1:0] EXT_IRQ_I,
    input  wire logic [`IPW_NUM_SRC-1:0] PERIPH_EVT_I,
    input  wire logic                    VEC_ACK_I,
    input  wire logic                    RETI_I,
    output ipw_grant_t                   GRANT_O,
    output logic                         IRQ_O,
    output ipw_clk_ctrl_t                CLK_CTRL_O
);
    localparam int NS = `IPW_NUM_SRC;
    localparam int NV = `IPW_NUM_VEC;
    localparam int NE = `IPW_NUM_EXT;
    localparam int EXT_POS [NE] = `IPW_EXT_POS;
    localparam logic [NS-1:0] VMASK [NV] = '{
        `IPW_VMASK0, `IPW_VMASK1, `IPW_VMASK2, `IPW_VMASK3, `IPW_VMASK4,
        `IPW_VMASK5, `IPW_VMASK6, `IPW_VMASK7, `IPW_VMASK8, `IPW_VMASK9};
    localparam logic [3:0] OSC_RST = `IPW_OSC_RST;

    logic [NE-1:0]   ext_meta_reg;
    logic [NE-1:0]   ext_sync_reg;
    logic [NE-1:0]   ext_prev_reg;
    logic [NE-1:0]   ext_evt;
    logic [NS-1:0]   ext_src;
    logic [NS-1:0]   ext_pos_mask;
    logic [NS-1:0]   src_evt;
    logic [NS-1:0]   pending_reg;
    logic [NS-1:0]   enable_reg;
    logic [NS-1:0]   pend_clr;
    logic [NS-1:0]   active_req;
    logic [NV-1:0]   level_reg;
    logic [15:0]     extcfg_reg;
    logic [3:0]      osc_reg;
    ipw_mode_t       mode_reg;
    ipw_mode_t       mode_next;
    logic [2:0]      insvc_reg;
    logic [2:0]      insvc_next;
    logic [1:0]      cur_lvl;
    logic [NV-1:0]   vreq;
    logic [1:0]      vlvl [NV];
    logic [1:0]      best_lvl;
    logic [7:0]      best_addr;
    ipw_grant_t      grant_reg;
    ipw_grant_t      grant_next;
    logic            irq_reg;
    ipw_clk_ctrl_t   clk_reg;
    ipw_clk_ctrl_t   clk_next;
    logic            halt_wake;
    logic            stop_wake;
    logic            xstop_wake;
    logic            apb_setup;
    logic            apb_acc;
    logic            wr;
    logic            hit;
    logic [31:0]     rdata;
    logic [31:0]     prdata_reg;
    logic            pready_reg;
    logic            pslverr_reg;

    // external pins: two-stage synchroniser, then edge or level detect
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            ext_meta_reg <= '0;
            ext_sync_reg <= '0;
            ext_prev_reg <= '0;
        end else begin
            ext_meta_reg <= EXT_IRQ_I;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    // act: pin at its set polarity; edge mode fires only on the cycle act rises
    generate
        for (genvar e = 0; e < NE; e++) begin : g_ext
            logic act;
            logic act_prev;
            assign act      = ext_sync_reg[e] == extcfg_reg[`IPW_EXTCFG_POL + e];
            assign act_prev = ext_prev_reg[e] == extcfg_reg[`IPW_EXTCFG_POL + e];
            assign ext_evt[e] = extcfg_reg[e] ? act : (act & ~act_prev);
        end
    endgenerate

    always_comb begin
        ext_src      = '0;
        ext_pos_mask = '0;
        for (int e = 0; e < NE; e++) begin
            ext_src[EXT_POS[e]]      = ext_evt[e];
            ext_pos_mask[EXT_POS[e]] = 1'b1;
        end
    end

    // pin sources replace the peripheral lines at their positions
    assign src_evt = (PERIPH_EVT_I & ~ext_pos_mask) | ext_src;

    // apb slave: pready in the first cycle of the access phase, no wait state
    assign apb_setup = PSEL_I & ~PENABLE_I;
    assign apb_acc   = PSEL_I & PENABLE_I & pready_reg;
    assign wr        = apb_acc & PWRITE_I;

    // read mux; an unmapped offset answers with the slave error
    always_comb begin
        hit   = 1'b1;
        rdata = '0;
        unique case (PADDR_I)
            `IPW_PEND_LO_OFS: rdata = pending_reg[31:0];
            `IPW_PEND_HI_OFS: rdata = {25'h0000000, pending_reg[NS-1:32]};
            `IPW_EN_LO_OFS:   rdata = enable_reg[31:0];
            `IPW_EN_HI_OFS:   rdata = {25'h0000000, enable_reg[NS-1:32]};
            `IPW_LEVEL_OFS:   rdata = {22'h000000, level_reg};
            `IPW_EXTCFG_OFS:  rdata = {16'h0000, extcfg_reg};
            `IPW_OSC_OFS:     rdata = {28'h0000000, osc_reg};
            `IPW_STATUS_OFS:  rdata = {24'h000000, grant_reg.valid, mode_reg, insvc_reg, cur_lvl};
            `IPW_STBY_OFS:    rdata = {30'h00000000, mode_reg};
            default:          hit   = 1'b0;
        endcase
    end

    // read data is latched at setup, so a read shows the state before that edge
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= apb_setup;
            pslverr_reg <= apb_setup & ~hit;
            prdata_reg  <= (apb_setup & ~PWRITE_I) ? rdata : '0;
        end
    end

    // pending flags: write one to clear, a new event wins over the clear
    always_comb begin
        pend_clr = '0;
        if (wr && PADDR_I == `IPW_PEND_LO_OFS)
            pend_clr[31:0] = PWDATA_I;
        if (wr && PADDR_I == `IPW_PEND_HI_OFS)
            pend_clr[NS-1:32] = PWDATA_I[NS-33:0];
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I)
            pending_reg <= '0;
        else
            pending_reg <= (pending_reg & ~pend_clr) | src_evt;
    end

    // configuration registers
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            enable_reg <= `IPW_EN_RST;
            level_reg  <= `IPW_LEVEL_RST;
            extcfg_reg <= `IPW_EXTCFG_RST;
            osc_reg    <= `IPW_OSC_RST;
        end else if (wr) begin
            if (PADDR_I == `IPW_EN_LO_OFS)
                enable_reg[31:0] <= PWDATA_I;
            if (PADDR_I == `IPW_EN_HI_OFS)
                enable_reg[NS-1:32] <= PWDATA_I[NS-33:0];
            if (PADDR_I == `IPW_LEVEL_OFS)
                level_reg <= PWDATA_I[NV-1:0];
            if (PADDR_I == `IPW_EXTCFG_OFS)
                extcfg_reg <= PWDATA_I[15:0];
            if (PADDR_I == `IPW_OSC_OFS)
                osc_reg <= PWDATA_I[3:0];
        end
    end

    // a disabled flag still latches but neither requests nor wakes
    assign active_req = pending_reg & enable_reg;

    // vector requests and their levels
    generate
        for (genvar v = 0; v < NV; v++) begin : g_vec
            assign vreq[v] = |(active_req & VMASK[v]);
            if (v < `IPW_NUM_XL_VEC) begin : g_xl
                assign vlvl[v] = level_reg[v] ? `IPW_LVL_X : `IPW_LVL_L;
            end else begin : g_hl
                assign vlvl[v] = level_reg[v] ? `IPW_LVL_H : `IPW_LVL_L;
            end
        end
    endgenerate

    // arbitration: strict compare in ascending order keeps the smallest vector
    always_comb begin
        best_lvl  = `IPW_LVL_NONE;
        best_addr = `IPW_VEC_BASE;
        for (int v = 0; v < NV; v++) begin
            if (vreq[v] && vlvl[v] > best_lvl) begin
                best_lvl  = vlvl[v];
                best_addr = `IPW_VEC_BASE + 8'(v) * `IPW_VEC_STEP;
            end
        end
    end

    // in-service levels: bit 0 low, bit 1 high, bit 2 highest
    always_comb begin
        if (insvc_reg[2])
            cur_lvl = `IPW_LVL_X;
        else if (insvc_reg[1])
            cur_lvl = `IPW_LVL_H;
        else if (insvc_reg[0])
            cur_lvl = `IPW_LVL_L;
        else
            cur_lvl = `IPW_LVL_NONE;
    end

    // a return pops first, so an accept in the same cycle survives it
    always_comb begin
        insvc_next = insvc_reg;
        if (RETI_I) begin
            if (insvc_next[2])
                insvc_next[2] = 1'b0;
            else if (insvc_next[1])
                insvc_next[1] = 1'b0;
            else
                insvc_next[0] = 1'b0;
        end
        if (VEC_ACK_I && grant_reg.valid)
            insvc_next[grant_reg.level - 2'h1] = 1'b1;
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I)
            insvc_reg <= '0;
        else
            insvc_reg <= insvc_next;
    end

    // offer a vector only when strictly above the level in service
    always_comb begin
        grant_next = '0;
        if (!(VEC_ACK_I && grant_reg.valid) && best_lvl > cur_lvl) begin
            grant_next.valid = 1'b1;
            grant_next.level = best_lvl;
            grant_next.addr  = best_addr;
        end
    end

    // the interrupt line follows the enabled flags one cycle late
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            grant_reg <= '0;
            irq_reg   <= 1'b0;
        end else begin
            grant_reg <= grant_next;
            irq_reg   <= |active_req;
        end
    end

    // standby wake sources
    assign halt_wake = |active_req;
    // ext 0 and 1 count only when set level-sensitive
    assign stop_wake = (active_req[`IPW_SRC_EXT_IRQ_ZERO] & extcfg_reg[0])
                     | (active_req[`IPW_SRC_EXT_IRQ_ONE] & extcfg_reg[1])
                     | active_req[`IPW_SRC_EXT_IRQ_TWO]
                     | active_req[`IPW_SRC_EXT_IRQ_FOUR]
                     | active_req[`IPW_SRC_EXT_IRQ_FIVE]
                     | active_req[`IPW_SRC_PORT0]
                     | active_req[`IPW_SRC_BUSA]
                     | active_req[`IPW_SRC_BUSB];
    assign xstop_wake = stop_wake | active_req[`IPW_SRC_BTIMER];

    // standby is entered only from run; a mode write in standby is dropped
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            IPW_RUN: begin
                if (wr && PADDR_I == `IPW_STBY_OFS)
                    mode_next = ipw_mode_t'(PWDATA_I[1:0]);
            end
            IPW_HALT: begin
                if (halt_wake)
                    mode_next = IPW_RUN;
            end
            IPW_STOP: begin
                if (stop_wake)
                    mode_next = IPW_RUN;
            end
            IPW_XSTOP: begin
                if (xstop_wake)
                    mode_next = IPW_RUN;
            end
        endcase
    end

    // reset pin and watchdog reset both arrive merged on RST_I
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I)
            mode_reg <= IPW_RUN;
        else
            mode_reg <= mode_next;
    end

    // clock and run controls follow the next mode
    always_comb begin
        clk_next.core_run       = mode_next == IPW_RUN;
        clk_next.periph_run     = mode_next == IPW_RUN || mode_next == IPW_HALT;
        clk_next.base_timer_run = mode_next != IPW_STOP;
        clk_next.rc_en          = osc_reg[`IPW_OSC_RC];
        clk_next.cf_en          = osc_reg[`IPW_OSC_CF];
        clk_next.xtal_en        = osc_reg[`IPW_OSC_XTAL];
        clk_next.pll_en         = osc_reg[`IPW_OSC_PLL];
        if (mode_next == IPW_STOP || mode_next == IPW_XSTOP) begin
            clk_next.rc_en  = 1'b0;
            clk_next.cf_en  = 1'b0;
            clk_next.pll_en = 1'b0;
        end
        // crystal stop leaves the crystal as programmed at entry
        if (mode_next == IPW_STOP)
            clk_next.xtal_en = 1'b0;
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            clk_reg.core_run       <= 1'b1;
            clk_reg.periph_run     <= 1'b1;
            clk_reg.base_timer_run <= 1'b1;
            clk_reg.rc_en          <= OSC_RST[`IPW_OSC_RC];
            clk_reg.cf_en          <= OSC_RST[`IPW_OSC_CF];
            clk_reg.xtal_en        <= OSC_RST[`IPW_OSC_XTAL];
            clk_reg.pll_en         <= OSC_RST[`IPW_OSC_PLL];
        end else begin
            clk_reg <= clk_next;
        end
    end

    // every output is a register
    assign PRDATA_O   = prdata_reg;
    assign PREADY_O   = pready_reg;
    assign PSLVERR_O  = pslverr_reg;
    assign GRANT_O    = grant_reg;
    assign IRQ_O      = irq_reg;
    assign CLK_CTRL_O = clk_reg;
endmodule // ipw_irq_ctrl

`default_nettype wire

// >>> design/ipw_params.svh
// constants of the interrupt priority and wake controller
// assumes a 32-bit APB register bus with byte addresses
`ifndef IPW_PARAMS_SVH
`define IPW_PARAMS_SVH

`define IPW_NUM_SRC      39
`define IPW_NUM_VEC      10
`define IPW_NUM_EXT      8
`define IPW_ADDR_W       8
`define IPW_VADDR_W      8

// register byte offsets
`define IPW_PEND_LO_OFS  8'h00
`define IPW_PEND_HI_OFS  8'h04
`define IPW_EN_LO_OFS    8'h08
`define IPW_EN_HI_OFS    8'h0C
`define IPW_LEVEL_OFS    8'h10
`define IPW_EXTCFG_OFS   8'h14
`define IPW_OSC_OFS      8'h18
`define IPW_STATUS_OFS   8'h1C
`define IPW_STBY_OFS     8'h20

// reset values
`define IPW_EN_RST       39'h00_0000_0000
`define IPW_LEVEL_RST    10'h000
`define IPW_EXTCFG_RST   16'h0000
`define IPW_OSC_RST      4'h1

// field positions
`define IPW_EXTCFG_POL   8
`define IPW_OSC_RC       0
`define IPW_OSC_CF       1
`define IPW_OSC_XTAL     2
`define IPW_OSC_PLL      3

// level codes, ordered so that a larger code outranks a smaller one
`define IPW_LVL_NONE     2'h0
`define IPW_LVL_L        2'h1
`define IPW_LVL_H        2'h2
`define IPW_LVL_X        2'h3

// vector address = base + index * step
`define IPW_VEC_BASE     8'h03
`define IPW_VEC_STEP     8'h08
`define IPW_NUM_XL_VEC   2

// source membership of each vector
`define IPW_VMASK0       39'h00_0000_0001
`define IPW_VMASK1       39'h00_0000_0002
`define IPW_VMASK2       39'h00_0000_007C
`define IPW_VMASK3       39'h00_0000_0380
`define IPW_VMASK4       39'h00_0000_7C00
`define IPW_VMASK5       39'h00_001F_8000
`define IPW_VMASK6       39'h00_0060_0000
`define IPW_VMASK7       39'h00_0380_0000
`define IPW_VMASK8       39'h01_FC00_0000
`define IPW_VMASK9       39'h7E_0000_0000

// source positions of the external pins, pin 0 first
`define IPW_EXT_POS      '{0, 1, 2, 7, 4, 8, 11, 17}
`define IPW_SRC_EXT_IRQ_ZERO     0
`define IPW_SRC_EXT_IRQ_ONE     1
`define IPW_SRC_EXT_IRQ_TWO     2
`define IPW_SRC_EXT_IRQ_FOUR     4
`define IPW_SRC_BUSA     5
`define IPW_SRC_BUSB     6
`define IPW_SRC_EXT_IRQ_FIVE     8
`define IPW_SRC_BTIMER   9
`define IPW_SRC_PORT0    33

`endif

// >>> design/ipw_pkg.sv
// types of the interrupt priority and wake controller
// assumes ipw_params.svh for all numeric constants
package ipw_pkg;
    typedef enum logic [1:0] {
        IPW_RUN,
        IPW_HALT,
        IPW_STOP,
        IPW_XSTOP
    } ipw_mode_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] level;
        logic [7:0] addr;
    } ipw_grant_t;

    typedef struct packed {
        logic core_run;
        logic periph_run;
        logic base_timer_run;
        logic rc_en;
        logic cf_en;
        logic xtal_en;
        logic pll_en;
    } ipw_clk_ctrl_t;
endpackage
